// ---- emb_defs.svh ----
/*
  Constants for the external memory bus pin controller: register byte
  offsets, field positions, reset values and timing figures.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave
// ----------------------------------------------------------------------
`define EMB_MEMORY_BUS_CONTROL_OFS 8'h00
`define EMB_PADCFG_OFS 8'h04
`define EMB_PMD_OFS 8'h08
`define EMB_STAT_OFS 8'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EMB_REL_BIT 7
`define EMB_WAIT_HI 5
`define EMB_WAIT_LO 4
`define EMB_WM_HI 1
`define EMB_WM_LO 0
`define EMB_PU_HI 7
`define EMB_PU_LO 5
`define EMB_OFF_BIT 0

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define EMB_MEMORY_BUS_CONTROL_RST 8'h30
`define EMB_MEMORY_BUS_CONTROL_MASK 8'hb3
`define EMB_PU_RST 3'h0
`define EMB_PMD_RST 8'h00

// ----------------------------------------------------------------------
// Timing: instruction cycle and bus phase lengths
// ----------------------------------------------------------------------
`define EMB_CLK_NS 5
`define EMB_TCY_NS 20
`define EMB_TCY_CLKS ((`EMB_TCY_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)
`define EMB_DATA_CYC 5'h03

`endif

// ---- emb_pkg.sv ----
/*
  Types for the external memory bus pin controller: bus cycle states,
  width configurations and core access kinds.
  Assumes emb_defs.svh supplies the numeric constants.
*/
package emb_pkg;

  typedef enum logic [4:0] {
    EMB_IDLE = 5'h01,
    EMB_ADDR = 5'h02,
    EMB_DATA = 5'h04,
    EMB_WAIT = 5'h08,
    EMB_DONE = 5'h10
  } emb_st_t;

  typedef enum logic [1:0] {
    EMB_BYTE_WRITE = 2'h0,
    EMB_WORD_WRITE = 2'h1,
    EMB_BYTE_SELECT = 2'h2
  } emb_cfg_t;

  typedef enum logic [1:0] {
    EMB_FETCH = 2'h0,
    EMB_TBLRD = 2'h1,
    EMB_TBLWR = 2'h2
  } emb_acc_t;

endpackage

// ---- emb_sync.sv ----
/*
  Two flip-flop synchroniser for pin inputs.
  Assumes the inputs are quasi-static across a couple of clock edges.
*/
`timescale 1ns/1ps
module emb_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] d, // Raw pin levels
  output logic [W-1:0] q // Synchronised levels
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("emb_sync: W must be at least 1");
  end

  // First stage is read only by the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // emb_sync

// ---- emb_wmtable.sv ----
/*
  Width-mode table: maps the two-bit width-mode field onto one of the
  three 16-bit data width configurations. Unlisted codes fall back to
  word write. Assumes the three codes are distinct.
*/
`timescale 1ns/1ps
module emb_wmtable
  import emb_pkg::*;
#(
  parameter logic [1:0] CODE_BW = 2'h0,
  parameter logic [1:0] CODE_WW = 2'h1,
  parameter logic [1:0] CODE_BS = 2'h2
) (
  input wire logic [1:0] wm, // Width-mode field
  output emb_cfg_t cfg // Selected configuration
);
  initial begin
    if (CODE_BW == CODE_WW || CODE_BW == CODE_BS || CODE_WW == CODE_BS)
      $error("emb_wmtable: width-mode codes must be distinct");
  end

  always_comb begin
    if (wm == CODE_BW) cfg = EMB_BYTE_WRITE;
    else if (wm == CODE_BS) cfg = EMB_BYTE_SELECT;
    else cfg = EMB_WORD_WRITE;
  end
endmodule // emb_wmtable

// ---- emb_pin_ctrl.sv ----
/*
  External memory bus pin controller: register file on AHB-Lite, the
  bus cycle sequencer for fetches and table operations, and the choice
  between bus and port function on the shared pins.
  Assumes the core gives same-clock access requests and low-power
  levels, and the port logic uses own_lo/own_hi to pick bus over port.

*/
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "emb_defs.svh"
module emb_pin_ctrl
  import emb_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int TCY_CLKS = `EMB_TCY_CLKS,
  parameter logic [1:0] CODE_BW = 2'h0,
  parameter logic [1:0] CODE_WW = 2'h1,
  parameter logic [1:0] CODE_BS = 2'h2
) (
  input wire logic ref_clk, // Core instruction clock
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic single_chip_pin, // Strap: single-chip mode
  input wire logic wait_en, // Wait states configured on
  input wire logic exec_ext, // Core executing from external
  input wire logic sleep_mode, // Core in Sleep
  input wire logic idle_mode, // Core in Idle
  input wire logic acc_req, // External access request
  input wire logic [1:0] acc_kind, // Fetch, table read, table write
  input wire logic [19:0] acc_addr, // Byte address
  input wire logic [15:0] acc_wdata, // Write data
  output logic acc_ready, // Request may be taken
  output logic acc_done, // Access finished, one cycle
  output logic [15:0] acc_rdata, // Read word
  input wire logic [15:0] ad_in, // Address/data pin levels
  output logic [15:0] ad_out, // Address/data drive value
  output logic [15:0] ad_oe, // Address/data drive enable
  output logic [3:0] a_hi_out, // Upper address drive value
  output logic [3:0] a_hi_oe, // Upper address drive enable
  output logic ce_n, // Chip enable, active low
  output logic oe_n, // Output enable, active low
  output logic write_high_strobe_n, // High byte write, active low
  output logic write_low_strobe_n, // Low byte write, active low
  output logic upper_byte_sel_n, // Upper byte select, active low
  output logic lower_byte_sel_n, // Lower byte select, active low
  output logic ale, // Address latch strobe
  output logic byte_addr_line, // Flash byte address
  output logic own_lo, // Bus owns AD pins over ports
  output logic own_hi, // Bus owns upper address pins
  output logic [2:0] pullup_en // Pull-ups for ports d, e, j
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    emb_st_t st;
    logic [4:0] cnt;
    logic [7:0] memory_bus_control;
    logic [2:0] pu;
    logic [7:0] pmd;
    logic rel_eff;
    logic strap_done;
    logic [1:0] strap_cnt;
    logic single;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] a_idx;
    logic hready;
    logic [31:0] hrdata;
    logic acc_ready;
    logic acc_done;
    logic [15:0] acc_rdata;
    logic is_wr;
    logic is_tbl;
    logic [19:0] lat_addr;
    logic [15:0] lat_wdata;
    logic [15:0] ad_out;
    logic [15:0] ad_oe;
    logic [3:0] a_hi;
    logic [3:0] a_hi_oe;
    logic ce_n;
    logic oe_n;
    logic wrh_n;
    logic wrl_n;
    logic ub_n;
    logic lb_n;
    logic ale;
    logic ba;
    logic own_lo;
    logic own_hi;
  } emb_state_t;

  emb_state_t s_q, s_d;
  logic [16:0] pins_s;
  emb_cfg_t cfg;
  logic lowp;
  logic bus_on;
  logic take;

  initial begin
    if (ADDR_W != 16 && ADDR_W != 20)
      $error("emb_pin_ctrl: ADDR_W must be 16 or 20");
    if (TCY_CLKS < 1 || TCY_CLKS > 8)
      $error("emb_pin_ctrl: TCY_CLKS must be 1 to 8");
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [4:0] wait_clks(input logic [1:0] w);
    wait_clks = 5'(int'(w) * TCY_CLKS);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] idx,
                                           input emb_state_t s);
    logic [31:0] r;
    r = 32'h0;
    unique case (idx)
      `EMB_MEMORY_BUS_CONTROL_OFS: r[7:0] = s.memory_bus_control;
      `EMB_PADCFG_OFS: r[`EMB_PU_HI:`EMB_PU_LO] = s.pu;
      `EMB_PMD_OFS: r[7:0] = s.pmd;
      `EMB_STAT_OFS: r[15:0] = {s.st, 2'(cfg), s.single, s.rel_eff,
                                s.own_hi, s.own_lo, lowp, s.acc_ready,
                                s.is_tbl, s.is_wr, 1'b0};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  emb_sync #(.W(17)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({single_chip_pin, ad_in}),
    .q(pins_s)
  );

  emb_wmtable #(
    .CODE_BW(CODE_BW),
    .CODE_WW(CODE_WW),
    .CODE_BS(CODE_BS)
  ) u_wm (
    .wm(s_q.memory_bus_control[`EMB_WM_HI:`EMB_WM_LO]),
    .cfg(cfg)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  // Run modes at a slower clock need nothing here: every phase is
  // counted in clock edges, so the bus simply stretches.
  assign lowp = sleep_mode | idle_mode;
  assign bus_on = s_q.strap_done & ~s_q.single &
                  ~s_q.pmd[`EMB_OFF_BIT];
  assign take = acc_req & s_q.acc_ready;

  always_comb begin
    s_d = s_q;
    s_d.acc_done = 1'b0;

    // Strap is caught once, on the third edge after reset release, so
    // the synchroniser has flushed its reset value first
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt == 2'h2) begin
        s_d.strap_done = 1'b1;
        s_d.single = pins_s[16];
      end else begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
    end

    // AHB-Lite slave: writes in zero waits, reads with one wait
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      unique case (s_q.a_idx)
        `EMB_MEMORY_BUS_CONTROL_OFS: begin
          if (!s_q.single)
            s_d.memory_bus_control = hwdata[7:0] & `EMB_MEMORY_BUS_CONTROL_MASK;
        end
        `EMB_PADCFG_OFS: s_d.pu = hwdata[`EMB_PU_HI:`EMB_PU_LO];
        `EMB_PMD_OFS: s_d.pmd = hwdata[7:0];
        default: s_d.pmd = s_q.pmd;
      endcase
    end
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.hrdata = reg_read(s_q.a_idx, s_q);
      s_d.hready = 1'b1;
    end
    if (hsel && htrans[1] && hready) begin
      s_d.a_idx = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = ~hwrite;
      s_d.hready = hwrite;
    end

    // A release set while running externally is held back until
    // execution returns inside; clearing it acts at once.
    if (!exec_ext)
      s_d.rel_eff = s_q.memory_bus_control[`EMB_REL_BIT];
    else if (!s_q.memory_bus_control[`EMB_REL_BIT])
      s_d.rel_eff = 1'b0;

    // Bus cycle sequencer; frozen in Sleep or Idle, except ce_n and the byte selects, which are forced high, and acc_ready, which is forced low
    if (!lowp) begin
      unique case (s_q.st)
        EMB_IDLE: begin
          s_d.ad_oe = 16'h0;
          s_d.a_hi_oe = 4'h0;
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.wrh_n = 1'b1;
          s_d.wrl_n = 1'b1;
          s_d.ub_n = 1'b1;
          s_d.lb_n = 1'b1;
          s_d.ale = 1'b0;
          s_d.ba = 1'b0;
          if (take) begin
            s_d.st = EMB_ADDR;
            s_d.acc_ready = 1'b0;
            s_d.lat_addr = acc_addr;
            s_d.lat_wdata = acc_wdata;
            s_d.is_wr = (acc_kind == 2'(EMB_TBLWR));
            s_d.is_tbl = (acc_kind != 2'(EMB_FETCH));
            // Word address on AD; the byte select mode puts the byte
            // offset on its own line instead.
            s_d.ad_out = acc_addr[16:1];
            s_d.ad_oe = 16'hffff;
            s_d.a_hi = (ADDR_W == 20) ? {1'b0, acc_addr[19:17]} : 4'h0;
            s_d.a_hi_oe = (ADDR_W == 20) ? 4'hf : 4'h0;
            s_d.ale = 1'b1;
            s_d.ce_n = 1'b0;
            s_d.ba = (cfg == EMB_BYTE_SELECT) & acc_addr[0];
            s_d.cnt = `EMB_DATA_CYC;
          end
        end
        EMB_ADDR: begin
          s_d.ale = 1'b0;
          s_d.st = EMB_DATA;
          if (s_q.is_wr) begin
            s_d.ad_out = (cfg == EMB_WORD_WRITE) ? s_q.lat_wdata :
                         {s_q.lat_wdata[7:0], s_q.lat_wdata[7:0]};
            unique case (cfg)
              EMB_BYTE_WRITE: begin
                s_d.wrh_n = ~s_q.lat_addr[0];
                s_d.wrl_n = s_q.lat_addr[0];
                s_d.ub_n = 1'b0;
                s_d.lb_n = 1'b0;
              end
              EMB_WORD_WRITE: begin
                s_d.wrh_n = 1'b0;
                s_d.wrl_n = 1'b0;
                s_d.ub_n = 1'b0;
                s_d.lb_n = 1'b0;
              end
              EMB_BYTE_SELECT: begin
                s_d.wrl_n = 1'b0;
                s_d.ub_n = ~s_q.lat_addr[0];
                s_d.lb_n = s_q.lat_addr[0];
              end
              default: s_d.wrl_n = 1'b1;
            endcase
          end else begin
            s_d.ad_oe = 16'h0;
            s_d.oe_n = 1'b0;
            s_d.ub_n = 1'b0;
            s_d.lb_n = 1'b0;
          end
        end
        EMB_DATA: begin
          if (s_q.cnt > 5'h1) begin
            s_d.cnt = s_q.cnt - 5'h1;
          end else if (s_q.is_tbl && wait_en &&
                       s_q.memory_bus_control[`EMB_WAIT_HI:`EMB_WAIT_LO] != 2'h0) begin
            s_d.st = EMB_WAIT;
            s_d.cnt = wait_clks(s_q.memory_bus_control[`EMB_WAIT_HI:`EMB_WAIT_LO]);
          end else begin
            s_d.st = EMB_DONE;
          end
        end
        EMB_WAIT: begin
          if (s_q.cnt > 5'h1) s_d.cnt = s_q.cnt - 5'h1;
          else s_d.st = EMB_DONE;
        end
        EMB_DONE: begin
          if (!s_q.is_wr) s_d.acc_rdata = pins_s[15:0];
          s_d.acc_done = 1'b1;
          s_d.st = EMB_IDLE;
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.wrh_n = 1'b1;
          s_d.wrl_n = 1'b1;
          s_d.ub_n = 1'b1;
          s_d.lb_n = 1'b1;
          s_d.ale = 1'b0;
          s_d.ba = 1'b0;
          s_d.ad_oe = 16'h0;
          s_d.a_hi_oe = 4'h0;
        end
        default: s_d.st = EMB_IDLE;
      endcase
      s_d.acc_ready = (s_d.st == EMB_IDLE) & bus_on & ~take;
    end else begin
      s_d.acc_ready = 1'b0;
      s_d.ce_n = 1'b1;
      s_d.ub_n = 1'b1;
      s_d.lb_n = 1'b1;
    end

    // Pin ownership: while it is on, the bus wins over ports and every
    // peripheral sharing the pins, unless released with no access running
    // or taken and no external execution.
    s_d.own_lo = bus_on & (exec_ext | s_q.st != EMB_IDLE | take |
                 ~s_d.rel_eff);
    s_d.own_hi = s_d.own_lo & (ADDR_W == 20);
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= EMB_IDLE;
      s_q.memory_bus_control <= `EMB_MEMORY_BUS_CONTROL_RST;
      s_q.pu <= `EMB_PU_RST;
      s_q.pmd <= `EMB_PMD_RST;
      s_q.hready <= 1'b1;
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.wrh_n <= 1'b1;
      s_q.wrl_n <= 1'b1;
      s_q.ub_n <= 1'b1;
      s_q.lb_n <= 1'b1;
      s_q.single <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign hreadyout = s_q.hready;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign acc_ready = s_q.acc_ready;
  assign acc_done = s_q.acc_done;
  assign acc_rdata = s_q.acc_rdata;
  assign ad_out = s_q.ad_out;
  assign ad_oe = s_q.ad_oe;
  assign a_hi_out = s_q.a_hi;
  assign a_hi_oe = s_q.a_hi_oe;
  assign ce_n = s_q.ce_n;
  assign oe_n = s_q.oe_n;
  assign write_high_strobe_n = s_q.wrh_n;
  assign write_low_strobe_n = s_q.wrl_n;
  assign upper_byte_sel_n = s_q.ub_n;
  assign lower_byte_sel_n = s_q.lb_n;
  assign ale = s_q.ale;
  assign byte_addr_line = s_q.ba;
  assign own_lo = s_q.own_lo;
  assign own_hi = s_q.own_hi;
  assign pullup_en = s_q.pu;
endmodule // emb_pin_ctrl

// ---- emb_mem_model.sv ----
/*
  Behavioural external memory on the bus pins: 256 words of static RAM.
  Assumes addresses are latched while ale is high at a ref_clk edge.
*/
`timescale 1ns/1ps
module emb_mem_model (
  input wire logic ref_clk, // Core clock
  input wire logic ce_n, // Chip enable, active low
  input wire logic oe_n, // Output enable, active low
  input wire logic ale, // Address latch strobe
  input wire logic write_high_strobe_n, // High byte write
  input wire logic write_low_strobe_n, // Low byte write
  input wire logic [15:0] ad, // Resolved AD wire
  output logic [15:0] q // Memory drive onto AD
);
  logic [15:0] mem [256];
  logic [7:0] adr_q = 8'h00;
  logic [15:0] last_q = 16'h0000;
  logic rd;
  assign rd = !ce_n && !oe_n;
  // Released lines show the inverse, so stale data can never pass
  assign q = rd ? mem[adr_q] : ~last_q;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h5a00 | 16'(i);
  always @(posedge ref_clk) begin
    if (ale) adr_q <= ad[7:0];
    if (rd) last_q <= mem[adr_q];
    if (!ce_n && !write_high_strobe_n) mem[adr_q][15:8] <= ad[15:8];
    if (!ce_n && !write_low_strobe_n) mem[adr_q][7:0] <= ad[7:0];
  end
endmodule // emb_mem_model

// ---- emb_pin_ctrl_props.sv ----
/*
  Assertions on the pin controller ports.
  Assumes one clock domain and the asynchronous reset rst.
*/
`timescale 1ns/1ps
module emb_pin_ctrl_props (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Reset, active high
  input wire logic single_chip_pin, // Strap
  input wire logic sleep_mode, // Sleep level
  input wire logic idle_mode, // Idle level
  input wire logic acc_req, // Access request
  input wire logic [1:0] acc_kind, // Access kind
  input wire logic acc_ready, // Request may be taken
  input wire logic acc_done, // Access finished
  input wire logic [15:0] ad_out, // AD value
  input wire logic [15:0] ad_oe, // AD enable
  input wire logic ce_n, // Chip enable
  input wire logic oe_n, // Output enable
  input wire logic write_high_strobe_n, // High write
  input wire logic write_low_strobe_n, // Low write
  input wire logic upper_byte_sel_n, // Upper select
  input wire logic lower_byte_sel_n, // Lower select
  input wire logic ale, // Address latch
  input wire logic byte_addr_line, // Byte address
  input wire logic own_lo, // Bus owns AD
  input wire logic own_hi // Bus owns upper address
);
  logic take;
  logic lp;
  assign take = acc_req && acc_ready;
  assign lp = sleep_mode || idle_mode;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_take_latch: assert property (
    take |=> ale && !ce_n && ad_oe == 16'hffff)
    else $error("address phase missing after take");
  a_read_oe: assert property (
    take && acc_kind != 2'h2 |=> ##1 !ale && !oe_n && ad_oe == 16'h0)
    else $error("output enable does not follow latch");
  a_take_owns: assert property (
    take |=> own_lo [*5]) else $error("pins not owned during access");
  a_done_late: assert property (
    take |=> !acc_done [*5]) else $error("access finished too early");
  a_idle_pins: assert property (
    acc_ready |-> ad_oe == 16'h0 && ce_n && oe_n && write_high_strobe_n
      && write_low_strobe_n && upper_byte_sel_n && lower_byte_sel_n
      && !ale && !byte_addr_line) else $error("idle pin state wrong");
  a_lp_high: assert property (
    lp |=> ce_n && upper_byte_sel_n && lower_byte_sel_n)
    else $error("select lines not high in low power");
  a_lp_freeze: assert property (
    lp [*2] |=> $stable(ad_out) && $stable(ad_oe) && $stable(ale)
      && $stable(oe_n)) else $error("bus moved while frozen");
  a_lp_refuse: assert property (
    lp [*2] |-> !acc_ready) else $error("access offered in low power");
  a_single_chip: assert property (
    single_chip_pin [*8] |-> !own_lo && !own_hi && !acc_ready
      && ad_oe == 16'h0) else $error("bus active in single-chip mode");
endmodule // emb_pin_ctrl_props

bind emb_pin_ctrl emb_pin_ctrl_props u_emb_pin_ctrl_props (
  .ref_clk, .rst, .single_chip_pin, .sleep_mode, .idle_mode, .acc_req,
  .acc_kind, .acc_ready, .acc_done, .ad_out, .ad_oe, .ce_n, .oe_n,
  .write_high_strobe_n, .write_low_strobe_n, .upper_byte_sel_n,
  .lower_byte_sel_n, .ale, .byte_addr_line, .own_lo, .own_hi);

// ---- emb_pin_ctrl_tb.sv ----
/*
  Self-checking bench: AHB-Lite register tasks, core access task and a
  memory model on the pins. Assumes the default 20-bit address width.
*/
`timescale 1ns/1ps
module emb_pin_ctrl_tb;
  localparam int TCY = 4;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, acc_kind = 2'h0;
  logic single_chip_pin = 1'b0, wait_en = 1'b0, exec_ext = 1'b0;
  logic sleep_mode = 1'b0, idle_mode = 1'b0, acc_req = 1'b0, b;
  logic [19:0] acc_addr = 20'h0;
  logic [15:0] acc_wdata = 16'h0, acc_rdata, ad_in, ad_out, ad_oe, mem_q;
  logic hreadyout, hresp, acc_ready, acc_done, ce_n, oe_n, ale;
  logic write_high_strobe_n, write_low_strobe_n, own_lo, own_hi;
  logic upper_byte_sel_n, lower_byte_sel_n, byte_addr_line;
  logic [3:0] a_hi_out, a_hi_oe;
  logic [2:0] pullup_en;
  int n, err_total = 0, n_checks = 0, cyc = 0;

  assign ad_in = (ad_oe & ad_out) | (~ad_oe & mem_q);

  emb_pin_ctrl #(.TCY_CLKS(TCY)) u_emb_pin_ctrl (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .single_chip_pin,
    .wait_en, .exec_ext, .sleep_mode, .idle_mode, .acc_req, .acc_kind,
    .acc_addr, .acc_wdata, .acc_ready, .acc_done, .acc_rdata, .ad_in,
    .ad_out, .ad_oe, .a_hi_out(), .a_hi_oe, .ce_n, .oe_n,
    .write_high_strobe_n, .write_low_strobe_n, .upper_byte_sel_n,
    .lower_byte_sel_n, .ale, .byte_addr_line, .own_lo, .own_hi, .pullup_en);

  emb_mem_model u_emb_mem_model (
    .ref_clk, .ce_n, .oe_n, .ale, .write_high_strobe_n,
    .write_low_strobe_n, .ad(ad_in), .q(mem_q));

  initial forever #2.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Counts edges from the take to the sampled done pulse
  task core(input logic [1:0] k, input logic [19:0] a, input logic [15:0] d);
    acc_req <= 1'b1;
    acc_kind <= k;
    acc_addr <= a;
    acc_wdata <= d;
    do @(posedge ref_clk); while (acc_ready !== 1'b1);
    acc_req <= 1'b0;
    n = 0;
    b = 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
      b = b | byte_addr_line;
    end while (acc_done !== 1'b1 && n < 64);
    r = {16'h0, acc_rdata};
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      chk(r, i == 0 ? 32'h30 : (i == 3 ? 32'h868 : 32'h0));
    end
    ahb(1'b1, 8'h04, 32'he0);
    ahb(1'b0, 8'h04, 32'h0);
    chk(r, 32'he0);
    chk(32'(pullup_en), 32'h7);
    ahb(1'b1, 8'h00, 32'h01);
    repeat (2) @(posedge ref_clk);
    chk(32'(own_lo), 32'h1);
    chk({ad_oe, a_hi_oe, ce_n, oe_n, write_high_strobe_n,
      write_low_strobe_n, upper_byte_sel_n, lower_byte_sel_n, ale,
      byte_addr_line}, 32'hfc);
    core(2'h2, 20'h00024, 16'hbeef);
    chk(32'(n), 32'h6);
    core(2'h0, 20'h00024, 16'h0);
    chk(r, 32'hbeef);
    chk(32'(b), 32'h0);
    // Odd byte write lands in the high half only
    ahb(1'b1, 8'h00, 32'h00);
    core(2'h2, 20'h00025, 16'h0011);
    core(2'h1, 20'h00024, 16'h0);
    chk(r, 32'h11ef);
    ahb(1'b1, 8'h00, 32'h02);
    core(2'h1, 20'h00025, 16'h0);
    chk(r, 32'h11ef);
    chk(32'(b), 32'h1);
    wait_en <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      ahb(1'b1, 8'h00, 32'(w * 16 + 1));
      core(2'h1, 20'h00024, 16'h0);
      chk(32'(n), 32'(6 + TCY * w));
    end
    core(2'h0, 20'h00024, 16'h0);
    chk(32'(n), 32'h6);
    ahb(1'b1, 8'h00, 32'h81);
    repeat (2) @(posedge ref_clk);
    chk(32'(own_lo), 32'h0);
    core(2'h1, 20'h00024, 16'h0);
    chk(r, 32'h11ef);
    repeat (3) @(posedge ref_clk);
    chk(32'(own_lo), 32'h0);
    // Release set while running outside waits for the internal branch
    ahb(1'b1, 8'h00, 32'h01);
    exec_ext <= 1'b1;
    ahb(1'b1, 8'h00, 32'h81);
    repeat (3) @(posedge ref_clk);
    chk(32'(own_lo), 32'h1);
    exec_ext <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(32'(own_lo), 32'h0);
    for (int i = 0; i < 2; i++) begin
      sleep_mode <= (i == 0);
      idle_mode <= (i == 1);
      repeat (3) @(posedge ref_clk);
      chk({ce_n, upper_byte_sel_n, lower_byte_sel_n, acc_ready},
        32'he);
    end
    sleep_mode <= 1'b0;
    idle_mode <= 1'b0;
    single_chip_pin <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ahb(1'b1, 8'h00, 32'h01);
    ahb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h30);
    chk({own_lo, own_hi, acc_ready}, 32'h0);
    tally_and_finish();
  end
endmodule // emb_pin_ctrl_tb
